// File: src/dmau_top.sv
// data memory access unit: address decode, cycle penalties, eeprom access
`timescale 1ns/1ns
`default_nettype none
`include "dmau_defines.svh"
module dmau_top
  import dmau_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        acc_req,
  input  wire logic        acc_we,
  input  wire logic        acc_io_short,
  input  wire logic        acc_stack_pc,
  input  wire logic [1:0]  acc_mode,
  input  wire logic [15:0] acc_addr,
  input  wire logic [15:0] acc_ptr,
  input  wire logic [5:0]  acc_disp,
  input  wire logic [4:0]  acc_ptr_lo,
  input  wire logic        ext_mem_enable,
  input  wire logic [1:0]  ext_wait_sel,
  input  wire logic        ee_osc_tick,
  input  wire logic        eeprom_write_arm,
  input  wire logic        eeprom_write_start,
  input  wire logic        eeprom_read_en,
  input  wire logic [11:0] eeprom_addr_reg,
  input  wire logic [7:0]  eeprom_data_wr,
  input  wire logic        eeprom_data_load,
  input  wire logic [7:0]  ee_array_rdata,
  output logic [15:0] eff_addr_q,
  output logic [2:0]  region_q,
  output logic        acc_fault_q,
  output logic [15:0] ptr_new_q,
  output logic        ptr_we_q,
  output logic [4:0]  ptr_sel_q,
  output logic        cpu_stall_q,
  output logic        ext_write_strobe_pin,
  output logic        ext_read_strobe_pin,
  output logic        ext_sel_q,
  output logic        eeprom_busy_q,
  output logic [7:0]  eeprom_data_reg,
  output logic        eeprom_write_arm_q,
  output logic        ee_array_we_q,
  output logic [11:0] ee_array_addr_q,
  output logic [7:0]  ee_array_wdata_q
);
  // ******************************
  // address formation
  // ******************************
  logic [15:0] ptr_dec;
  logic [15:0] ptr_inc;
  logic [15:0] addr_eff;
  logic        ptr_upd;
  assign ptr_dec  = acc_ptr - 16'h0001;
  assign ptr_inc  = acc_ptr + 16'h0001;
  assign addr_eff = (acc_mode == DMAU_MODE_DISP)   ? acc_ptr + {10'h000, acc_disp} :
                    (acc_mode == DMAU_MODE_PREDEC) ? ptr_dec :
                    (acc_mode == DMAU_MODE_POSTINC) ? acc_ptr : acc_addr;
  assign ptr_upd  = (acc_mode == DMAU_MODE_PREDEC) || (acc_mode == DMAU_MODE_POSTINC);

  // ******************************
  // region decode
  // ******************************
  logic         is_reg;
  logic         is_std;
  logic         is_xio;
  logic         is_sram;
  logic         is_ext;
  logic         internal;
  logic         fault;
  dmau_region_t region;
  assign is_reg   = addr_eff < `DMAU_REGFILE_END;
  assign is_std   = !is_reg && addr_eff < `DMAU_STDIO_END;
  assign is_xio   = addr_eff >= `DMAU_STDIO_END && addr_eff < `DMAU_EXTIO_END;
  assign is_sram  = addr_eff >= `DMAU_EXTIO_END && addr_eff < `DMAU_SRAM_END;
  assign is_ext   = addr_eff >= `DMAU_SRAM_END && ext_mem_enable;
  assign internal = addr_eff < `DMAU_SRAM_END;
  logic         ptr_bad;
  // displacement reaches only y or z; the stepping modes need x, y or z
  assign ptr_bad  = (acc_mode == DMAU_MODE_DISP) ?
                    (acc_ptr_lo != `DMAU_PTR_Y_LO && acc_ptr_lo != `DMAU_PTR_Z_LO) :
                    (ptr_upd && acc_ptr_lo != `DMAU_PTR_X_LO &&
                     acc_ptr_lo != `DMAU_PTR_Y_LO && acc_ptr_lo != `DMAU_PTR_Z_LO);
  // short i/o opcodes cannot see extended i/o; flagged, not routed
  assign fault    = (acc_io_short && is_xio) || (!internal && !ext_mem_enable) ||
                    ptr_bad;
  assign region   = fault   ? DMAU_REGION_NONE  :
                    is_ext  ? DMAU_REGION_EXT   :
                    is_sram ? DMAU_REGION_SRAM  :
                    is_xio  ? DMAU_REGION_EXTIO :
                    is_std  ? DMAU_REGION_STDIO : DMAU_REGION_REG;

  // ******************************
  // access timing
  // ******************************
  logic [3:0] extra;
  logic [3:0] acc_cycles;
  logic [3:0] wait_add;
  logic [3:0] acc_cnt_q;
  logic       ext_acc;
  assign ext_acc  = acc_req && is_ext && !fault;
  // one extra per byte without waits; with waits, waits+1 for one byte, the pc bytes plus twice the waits for a pc
  assign wait_add = (ext_wait_sel == 2'h0) ? 4'h1 : {2'h0, ext_wait_sel} + 4'h1;
  assign extra    = acc_stack_pc ?
                    ((ext_wait_sel == 2'h0) ? `DMAU_PC_BYTES :
                     {1'b0, ext_wait_sel, 1'b0} + `DMAU_PC_BYTES) : wait_add;
  assign acc_cycles = ext_acc ? `DMAU_INT_CYCLES + extra - 4'h1 : `DMAU_INT_CYCLES - 4'h1;

  logic        acc_busy;
  logic        acc_take;
  logic [3:0]  acc_cnt_d;
  logic        ext_sel_d;
  logic [15:0] ptr_new_d;
  assign acc_busy  = acc_cnt_q != 4'h0;
  assign acc_take  = acc_req && !acc_busy;
  assign acc_cnt_d = acc_busy ? acc_cnt_q - 4'h1 :
                     acc_take ? acc_cycles : 4'h0;
  // select held for the whole access, dropped once idle
  assign ext_sel_d = acc_busy ? ext_sel_q : ext_acc;
  assign ptr_new_d = (acc_mode == DMAU_MODE_PREDEC) ? ptr_dec : ptr_inc;

  // ******************************
  // access capture
  // ******************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_cnt_q <= 4'h0;
    end else begin
      acc_cnt_q <= acc_cnt_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eff_addr_q <= 16'h0000;
    end else if (acc_take) begin
      eff_addr_q <= addr_eff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      region_q <= 3'h0;
    end else if (acc_take) begin
      region_q <= region;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_fault_q <= 1'b0;
    end else if (acc_take) begin
      acc_fault_q <= fault;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ptr_new_q <= 16'h0000;
    end else if (acc_take) begin
      ptr_new_q <= ptr_new_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ptr_sel_q <= 5'h00;
    end else if (acc_take) begin
      ptr_sel_q <= acc_ptr_lo;
    end
  end

  // a refused pointer is not written back
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ptr_we_q <= 1'b0;
    end else begin
      ptr_we_q <= acc_take && ptr_upd && !ptr_bad;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_sel_q <= 1'b0;
    end else begin
      ext_sel_q <= ext_sel_d;
    end
  end

  // ******************************
  // external strobes
  // ******************************
  // strobes only move for external accesses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_write_strobe_pin <= 1'b0;
    end else begin
      ext_write_strobe_pin <= ext_sel_d && acc_we;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_read_strobe_pin <= 1'b0;
    end else begin
      ext_read_strobe_pin <= ext_sel_d && !acc_we;
    end
  end

  // ******************************
  // eeprom access
  // ******************************
  logic [2:0]  arm_cnt_q;
  logic [2:0]  arm_cnt_d;
  logic        arm_d;
  logic [2:0]  stall_cnt_q;
  logic        wr_go;
  logic        rd_go;
  logic        tmr_busy;
  logic [7:0]  data_reg_d;
  assign wr_go = eeprom_write_start && eeprom_write_arm_q && !tmr_busy;
  assign rd_go = eeprom_read_en && !tmr_busy;

  dmau_ee_timer u_timer (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (wr_go),
    .osc_tick (ee_osc_tick),
    .busy_q   (tmr_busy),
    .done_q   ()
  );

  // ******************************
  // eeprom arming
  // ******************************
  assign arm_cnt_d = eeprom_write_arm ? `DMAU_ARM_WINDOW :
                     (arm_cnt_q != 3'h0 && !wr_go) ? arm_cnt_q - 3'h1 : 3'h0;
  assign arm_d     = eeprom_write_arm ||
                     (arm_cnt_q != 3'h0 && !wr_go && arm_cnt_q != 3'h1);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arm_cnt_q <= 3'h0;
    end else begin
      arm_cnt_q <= arm_cnt_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eeprom_write_arm_q <= 1'b0;
    end else begin
      eeprom_write_arm_q <= arm_d;
    end
  end

  // ******************************
  // eeprom busy
  // ******************************
  // write-start bit reads back as busy until programming ends
  always_ff @(posedge ref_clk) begin
    eeprom_busy_q <= tmr_busy || wr_go;
  end

  // ******************************
  // eeprom stall
  // ******************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stall_cnt_q <= 3'h0;
      cpu_stall_q <= 1'b0;
    end else if (rd_go) begin
      stall_cnt_q <= `DMAU_EE_RD_STALL - 3'h1;
      cpu_stall_q <= 1'b1;
    end else if (wr_go) begin
      stall_cnt_q <= `DMAU_EE_WR_STALL - 3'h1;
      cpu_stall_q <= 1'b1;
    end else if (stall_cnt_q != 3'h0) begin
      stall_cnt_q <= stall_cnt_q - 3'h1;
      cpu_stall_q <= 1'b1;
    end else begin
      cpu_stall_q <= acc_busy;
    end
  end

  // ******************************
  // eeprom array
  // ******************************
  // one-byte array port; data register also takes cpu writes
  assign data_reg_d = rd_go ? ee_array_rdata :
                      eeprom_data_load ? eeprom_data_wr : eeprom_data_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eeprom_data_reg <= 8'h00;
    end else begin
      eeprom_data_reg <= data_reg_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ee_array_we_q <= 1'b0;
    end else begin
      ee_array_we_q <= wr_go;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ee_array_addr_q <= 12'h000;
    end else if (wr_go || rd_go) begin
      ee_array_addr_q <= eeprom_addr_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ee_array_wdata_q <= 8'h00;
    end else if (wr_go || rd_go) begin
      ee_array_wdata_q <= eeprom_data_reg;
    end
  end
endmodule : dmau_top
`default_nettype wire

// File: src/dmau_defines.svh
// constants for the data memory access unit
`ifndef DMAU_DEFINES_SVH
`define DMAU_DEFINES_SVH
`define DMAU_REGFILE_END  16'h0020
`define DMAU_STDIO_END    16'h0060
`define DMAU_EXTIO_END    16'h0200
`define DMAU_SRAM_END     16'h2200
`define DMAU_PTR_X_LO     5'h1a
`define DMAU_PTR_Y_LO     5'h1c
`define DMAU_PTR_Z_LO     5'h1e
`define DMAU_DISP_MAX     6'h3f
`define DMAU_INT_CYCLES   4'h2
`define DMAU_EE_RD_STALL  3'h4
`define DMAU_EE_WR_STALL  3'h2
`define DMAU_EE_PROG_CYC  15'h6700
`define DMAU_ARM_WINDOW   3'h4
`define DMAU_PC_BYTES     4'h3
`define DMAU_EE_AW        12
`endif

// File: src/dmau_pkg.sv
// types for the data memory access unit
package dmau_pkg;
  typedef enum logic [2:0] {
    DMAU_REGION_REG   = 3'h0,
    DMAU_REGION_STDIO = 3'h1,
    DMAU_REGION_EXTIO = 3'h2,
    DMAU_REGION_SRAM  = 3'h3,
    DMAU_REGION_EXT   = 3'h4,
    DMAU_REGION_NONE  = 3'h5
  } dmau_region_t;
  typedef enum logic [1:0] {
    DMAU_MODE_DIRECT = 2'h0,
    DMAU_MODE_DISP   = 2'h1,
    DMAU_MODE_PREDEC = 2'h2,
    DMAU_MODE_POSTINC = 2'h3
  } dmau_mode_t;
  typedef enum logic [1:0] {
    DMAU_ST_IDLE = 2'b00,
    DMAU_ST_BUSY = 2'b01,
    DMAU_ST_DONE = 2'b11
  } dmau_state_t;
endpackage : dmau_pkg

// File: src/dmau_ee_timer.sv
// self-timed eeprom programming counter on the rc oscillator tick
`timescale 1ns/1ns
`default_nettype none
`include "dmau_defines.svh"
module dmau_ee_timer
  import dmau_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic osc_tick,
  output logic      busy_q,
  output logic      done_q
);
  logic [14:0] cnt_q;
  logic        last;
  assign last = (cnt_q == `DMAU_EE_PROG_CYC - 15'h0001);
  // reset does not abort a write already counting
  always_ff @(posedge ref_clk) begin
    if (rst_n || busy_q) begin
      done_q <= busy_q && osc_tick && last;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q  <= 15'h0000;
      end else if (busy_q && osc_tick) begin
        cnt_q  <= last ? 15'h0000 : cnt_q + 15'h0001;
        if (last) busy_q <= 1'b0;
      end
    end else begin
      cnt_q  <= 15'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
  end
endmodule : dmau_ee_timer
`default_nettype wire

// File: bench/dmau_props.sv
// assertions on the access unit ports
`timescale 1ns/1ns
`default_nettype none
module dmau_props (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       ext_mem_enable,
  input wire logic       eeprom_write_start,
  input wire logic       eeprom_read_en,
  input wire logic [7:0] ee_array_rdata,
  input wire logic [2:0] region_q,
  input wire logic       acc_fault_q,
  input wire logic       cpu_stall_q,
  input wire logic       ext_write_strobe_pin,
  input wire logic       ext_read_strobe_pin,
  input wire logic       eeprom_busy_q,
  input wire logic [7:0] eeprom_data_reg,
  input wire logic       eeprom_write_arm_q,
  input wire logic       ee_array_we_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int_strobe_a: assert property (
    region_q != 3'h4 |-> !ext_read_strobe_pin && !ext_write_strobe_pin) else $error("strobe inside");
  ext_enable_a: assert property (
    ext_read_strobe_pin || ext_write_strobe_pin |-> ext_mem_enable) else $error("strobe while off");
  no_region_a: assert property (region_q == 3'h5 |-> acc_fault_q)
    else $error("no fault");
  rd_stall_a: assert property (
    eeprom_read_en && !eeprom_busy_q && !cpu_stall_q |=> cpu_stall_q [*4] ##1 !cpu_stall_q)
    else $error("read stall length");
  rd_data_a: assert property (
    eeprom_read_en && !eeprom_busy_q |=> eeprom_data_reg == $past(ee_array_rdata))
    else $error("read data");
  wr_go_a: assert property (
    eeprom_write_start && eeprom_write_arm_q && !eeprom_busy_q
    |=> (eeprom_busy_q && ee_array_we_q && cpu_stall_q) ##1 cpu_stall_q ##1 !cpu_stall_q)
    else $error("write start");
  no_arm_a: assert property (
    eeprom_write_start && !eeprom_write_arm_q && !eeprom_busy_q |=> !eeprom_busy_q)
    else $error("unarmed start taken");
  arm_clear_a: assert property (eeprom_write_start && eeprom_write_arm_q |=> !eeprom_write_arm_q)
    else $error("arm kept");
  busy_hold_a: assert property ($rose(eeprom_busy_q) |-> eeprom_busy_q [*8])
    else $error("busy dropped early");
endmodule : dmau_props
bind dmau_top dmau_props dmau_props_i (.ref_clk, .rst_n, .ext_mem_enable, .eeprom_write_start,
  .eeprom_read_en, .ee_array_rdata, .region_q, .acc_fault_q, .cpu_stall_q, .ext_write_strobe_pin,
  .ext_read_strobe_pin, .eeprom_busy_q, .eeprom_data_reg, .eeprom_write_arm_q, .ee_array_we_q);
`default_nettype wire

// File: bench/dmau_ee_mem.sv
// behavioural eeprom array behind the access unit
`timescale 1ns/1ns
`default_nettype none
module dmau_ee_mem (
  input  wire logic        ref_clk,
  input  wire logic        we,
  input  wire logic [11:0] waddr,
  input  wire logic [7:0]  wdata,
  input  wire logic [11:0] raddr,
  output logic [7:0]       rdata
);
  logic [7:0] mem_q [4096];
  // known pattern so a missed write shows on read back
  initial for (int i = 0; i < 4096; i++) mem_q[i] = 8'(i) ^ 8'h5a;
  always @(posedge ref_clk) if (we) mem_q[waddr] <= wdata;
  assign rdata = mem_q[raddr];
endmodule : dmau_ee_mem
`default_nettype wire

// File: bench/tb_top.sv
// self-checking testbench for the data memory access unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dmau_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, acc_req = 1'b0, acc_we = 1'b0, acc_io_short = 1'b0;
  logic acc_stack_pc = 1'b0, ext_mem_enable = 1'b0, ee_osc_tick = 1'b1, eeprom_write_arm = 1'b0;
  logic eeprom_write_start = 1'b0, eeprom_read_en = 1'b0, eeprom_data_load = 1'b0;
  logic ptr_we_q, cpu_stall_q, ext_write_strobe_pin, ext_read_strobe_pin, ext_sel_q;
  logic eeprom_busy_q, eeprom_write_arm_q, acc_fault_q, ee_array_we_q;
  logic [1:0]  acc_mode = 2'h0, ext_wait_sel = 2'h0;
  logic [15:0] acc_addr = 16'h0000, acc_ptr = 16'h1000, eff_addr_q, ptr_new_q;
  logic [5:0]  acc_disp = 6'h3f;
  logic [4:0]  acc_ptr_lo = 5'h1e, ptr_sel_q;
  logic [11:0] eeprom_addr_reg = 12'h123, ee_array_addr_q;
  logic [7:0]  eeprom_data_wr = 8'h00, ee_array_rdata, eeprom_data_reg, ee_array_wdata_q;
  logic [2:0]  region_q;
  int          bad_count = 0, cmp_count = 0, strb, n;
  dmau_top dmau_top_i (.*);
  dmau_ee_mem dmau_ee_mem_i (.ref_clk, .we(ee_array_we_q), .waddr(ee_array_addr_q),
    .wdata(ee_array_wdata_q), .raddr(eeprom_addr_reg), .rdata(ee_array_rdata));
  initial forever #4 ref_clk = ~ref_clk;
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // one access, then count strobe cycles while it runs
  task automatic acc(input logic [15:0] a, input logic [1:0] m, input logic io, input logic we);
    @(posedge ref_clk);
    acc_addr <= a;
    acc_mode <= m;
    acc_io_short <= io;
    acc_we <= we;
    acc_req <= 1'b1;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    strb = 0;
    repeat (12) @(posedge ref_clk) strb += int'(ext_read_strobe_pin | ext_write_strobe_pin);
  endtask : acc
  task automatic rd(input logic [7:0] e);
    @(posedge ref_clk);
    eeprom_read_en <= 1'b1;
    @(posedge ref_clk);
    eeprom_read_en <= 1'b0;
    #1 chk("ee read", 16'(e), 16'(eeprom_data_reg));
    chk("read stall", 16'h1, 16'(cpu_stall_q));
    repeat (6) @(posedge ref_clk);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic arm);
    @(posedge ref_clk);
    eeprom_addr_reg <= a;
    eeprom_data_wr <= d;
    eeprom_data_load <= 1'b1;
    eeprom_write_arm <= arm;
    @(posedge ref_clk);
    eeprom_data_load <= 1'b0;
    eeprom_write_arm <= 1'b0;
    eeprom_write_start <= 1'b1;
    @(posedge ref_clk);
    eeprom_write_start <= 1'b0;
    #1;
  endtask : wr
  // bounded wait for the self-timed write to finish
  task automatic wt;
    n = 0;
    while (eeprom_busy_q !== 1'b0 && n < 30000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 30000) begin
      bad_count++;
      close_out();
    end
  endtask : wt
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_map;
    logic [15:0] ad [8] = '{16'h0, 16'h1f, 16'h20, 16'h5f, 16'h60, 16'h1ff, 16'h200, 16'h21ff};
    for (int i = 0; i < 8; i++) begin
      acc(ad[i], 2'h0, 1'b0, i[0]);
      chk("region", 16'(i / 2), 16'(region_q));
      chk("eff addr", ad[i], eff_addr_q);
      chk("int strobes", 16'h0, 16'(strb));
    end
  endtask : t_map
  task automatic t_ext;
    int prev = 0;
    ext_mem_enable <= 1'b1;
    for (int w = 0; w < 4; w++) begin
      ext_wait_sel <= 2'(w);
      acc(16'h2200 + 16'(w), 2'h0, 1'b0, w[0]);
      chk("ext region", 16'h4, 16'(region_q));
      chk("strobes grow", 16'h1, 16'(strb > prev));
      prev = strb;
    end
    acc_stack_pc <= 1'b1;
    acc(16'hfff0, 2'h0, 1'b0, 1'b1);
    acc_stack_pc <= 1'b0;
    chk("stack strobes", 16'h1, 16'(strb > prev));
    ext_mem_enable <= 1'b0;
    acc(16'hffff, 2'h0, 1'b0, 1'b0);
    chk("off fault", 16'h1, 16'(acc_fault_q));
    chk("off strobes", 16'h0, 16'(strb));
  endtask : t_ext
  task automatic t_ptr;
    acc(16'h0, 2'h1, 1'b0, 1'b0);
    chk("disp addr", 16'h103f, eff_addr_q);
    acc(16'h0, 2'h2, 1'b0, 1'b0);
    chk("predec ptr", 16'h0fff, ptr_new_q);
    chk("ptr sel", 16'h1e, 16'(ptr_sel_q));
    acc(16'h0, 2'h3, 1'b0, 1'b1);
    chk("postinc ptr", 16'h1001, ptr_new_q);
    acc(16'h0100, 2'h0, 1'b1, 1'b0);
    chk("short io fault", 16'h1, 16'(acc_fault_q));
    acc_ptr_lo <= 5'h1a;
    acc(16'h0, 2'h1, 1'b0, 1'b0);
    chk("x disp fault", 16'h1, 16'(acc_fault_q));
    acc_ptr_lo <= 5'h1e;
  endtask : t_ptr
  task automatic t_ee;
    rd(8'h23 ^ 8'h5a);
    wr(12'h7ff, 8'hc3, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk("unarmed busy", 16'h0, 16'(eeprom_busy_q));
    wr(12'h7ff, 8'hc3, 1'b1);
    chk("armed busy", 16'h1, 16'(eeprom_busy_q));
    chk("array we", 16'h1, 16'(ee_array_we_q));
    chk("array addr", 16'h7ff, 16'(ee_array_addr_q));
    chk("array data", 16'hc3, 16'(ee_array_wdata_q));
    wt();
    chk("prog time", 16'h1, 16'(n >= 26360 && n <= 26372));
    rd(8'hc3);
  endtask : t_ee
  task automatic t_rst;
    wr(12'h0aa, 8'h3c, 1'b1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk("busy over reset", 16'h1, 16'(eeprom_busy_q));
    wt();
    rd(8'h3c);
  endtask : t_rst
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_map();
    t_ext();
    t_ptr();
    t_ee();
    t_rst();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
